// *** hw/fp_status_pkg.sv ***
// Constants, field layout and carriers for the floating-point status register.
// Assumes one core clock; bit positions follow the architectural numbering,
// so position 0 of every 32-bit mask below is the exception summary bit.
package fp_status_pkg;

  // ==========================================================================
  // Register geometry
  localparam int unsigned REG_W = 32;
  localparam int unsigned FIELD_W = 4;
  localparam int unsigned NUM_FIELDS = 8;
  localparam int unsigned STATUS_FIELDS = 6;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ==========================================================================
  // Status bit positions
  localparam int unsigned BIT_EXC_SUMMARY = 0;
  localparam int unsigned BIT_ENABLED_EXC_SUMMARY = 1;
  localparam int unsigned BIT_INVALID_OP_SUMMARY = 2;
  localparam int unsigned BIT_OVERFLOW_EXC = 3;
  localparam int unsigned BIT_UNDERFLOW_EXC = 4;
  localparam int unsigned BIT_ZERO_DIVIDE_EXC = 5;
  localparam int unsigned BIT_STICKY_INEXACT = 6;
  localparam int unsigned BIT_INVALID_SIGNALLING_NAN = 7;
  localparam int unsigned BIT_INVALID_INF_MINUS_INF = 8;
  localparam int unsigned BIT_INVALID_INF_DIV_INF = 9;
  localparam int unsigned BIT_INVALID_ZERO_DIV_ZERO = 10;
  localparam int unsigned BIT_INVALID_INF_TIMES_ZERO = 11;
  localparam int unsigned BIT_INVALID_COMPARE = 12;
  localparam int unsigned BIT_FRACTION_ROUNDED = 13;
  localparam int unsigned BIT_FRACTION_INEXACT = 14;
  localparam int unsigned BIT_RESULT_CLASS = 15;
  localparam int unsigned BIT_FP_CONDITION_CODE = 16;
  localparam int unsigned BIT_INVALID_SOFTWARE_REQUEST = 21;
  localparam int unsigned BIT_INVALID_SQUARE_ROOT = 22;
  localparam int unsigned BIT_INVALID_INT_CONVERT = 23;
  localparam int unsigned BIT_CTRL_LO = 24;

  // Control bit positions (held outside this block, mirrored here)
  localparam int unsigned BIT_EN_INVALID = 24;
  localparam int unsigned BIT_EN_OVERFLOW = 25;
  localparam int unsigned BIT_EN_UNDERFLOW = 26;
  localparam int unsigned BIT_EN_ZERO_DIVIDE = 27;
  localparam int unsigned BIT_EN_INEXACT = 28;

  // ==========================================================================
  // Bit groups
  localparam logic [31:0] EXC_MASK = 32'h00E0_1FF8;
  localparam logic [31:0] STICKY_MASK = 32'h00E0_1FF9;
  localparam logic [31:0] INVALID_MASK = 32'h00E0_1F80;
  localparam logic [31:0] DERIVED_MASK = 32'h0000_0006;
  localparam logic [31:0] RESERVED_MASK = 32'h0010_0000;
  localparam logic [31:0] STATUS_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] WRITABLE_MASK = 32'h00EF_FFF9;
  localparam logic [31:0] RESULT_FLAGS_MASK = 32'h000F_8000;
  localparam logic [31:0] COND_CODE_MASK = 32'h000F_0000;

  // ==========================================================================
  // Move-instruction opcodes, one-hot
  typedef enum logic [5:0] {
    MOVE_READ = 6'h01,
    MOVE_COPY_CRF = 6'h02,
    MOVE_IMM_FIELD = 6'h04,
    MOVE_FIELD = 6'h08,
    MOVE_BIT_CLR = 6'h10,
    MOVE_BIT_SET = 6'h20
  } move_op_t;

  // Compare outcome, mapped to one condition-code bit
  typedef enum logic [1:0] {
    CMP_LESS = 2'h0,
    CMP_GREATER = 2'h1,
    CMP_EQUAL = 2'h2,
    CMP_UNORDERED = 2'h3
  } cmp_result_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic overflow;
    logic underflow;
    logic zero_divide;
    logic [5:0] invalid_cause;
    logic invalid_square_root;
    logic invalid_int_convert;
    logic inexact_affect;
    logic fraction_inexact;
    logic rounded_affect;
    logic fraction_rounded;
    logic flags_affect;
    logic [4:0] result_flags;
    logic is_compare;
    cmp_result_t cmp_result;
  } pipe_report_t;

  typedef struct packed {
    logic valid;
    move_op_t op;
    logic [2:0] field;
    logic [4:0] bit_idx;
    logic [3:0] imm;
    logic [7:0] field_mask;
    logic [31:0] data;
  } move_req_t;

endpackage : fp_status_pkg

// *** hw/fp_summary_calc.sv ***
// Derived summaries of the floating-point status register.
// Assumes status and enables are presented on the same cycle; pure logic.
module fp_summary_calc (
  // Status and enables
  input wire logic [31:0] status,
  input wire logic [7:0] ctrl_bits,
  // Derived summaries
  output logic invalid_op_summary,
  output logic enabled_exc_summary
);

  // ==========================================================================
  // Summaries
  logic [31:0] en_vec;

  always_comb begin
    en_vec = {ctrl_bits, 24'h00_0000};
    invalid_op_summary = |(status & fp_status_pkg::INVALID_MASK);
    enabled_exc_summary =
      (invalid_op_summary & en_vec[fp_status_pkg::BIT_EN_INVALID]) |
      (status[fp_status_pkg::BIT_OVERFLOW_EXC] & en_vec[fp_status_pkg::BIT_EN_OVERFLOW]) |
      (status[fp_status_pkg::BIT_UNDERFLOW_EXC] & en_vec[fp_status_pkg::BIT_EN_UNDERFLOW]) |
      (status[fp_status_pkg::BIT_ZERO_DIVIDE_EXC] & en_vec[fp_status_pkg::BIT_EN_ZERO_DIVIDE]) |
      (status[fp_status_pkg::BIT_STICKY_INEXACT] & en_vec[fp_status_pkg::BIT_EN_INEXACT]);
  end

endmodule : fp_summary_calc

// *** hw/fp_status_control_register.sv ***
// Floating-point status and control register: sticky exception bits,
// derived summaries, rounding indicators and result flags.
// Assumes completion reports and move requests come from core-clock logic,
// and that the control byte (enables, rounding) is held by a neighbour.
// How it works
// - Bits 0-23 status, 24-31 control
// - Status changes only on completion report or move, except bit 1, which also follows an enable change
// - Exception bits stay set until moved clear
// - Exception 0-to-1 sets summary, except field moves
// - Moves and bit ops may write summary
// - Enabled summary is OR of masked exceptions
// - Invalid summary is OR of invalid causes
// - Overflow, underflow, zero-divide at 3, 4, 5
// - Sticky inexact ORs new fraction-inexact
// - Invalid causes 7-12 in fixed order
// - Fraction-rounded shows last rounding increment
// - Fraction-inexact: inexact or disabled overflow
// - Compare sets exactly one condition bit
// - Software-request bit changed only by moves
// - Square-root, convert causes at 22, 23
module fp_status_control_register (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Completion reports from the execution pipeline
  input wire fp_status_pkg::pipe_report_t pipe_report,
  // Move-to / move-from requests
  input wire fp_status_pkg::move_req_t move_req,
  // Control byte held outside (enables and rounding mode)
  input wire logic [7:0] ctrl_bits,
  // Register image
  output logic [31:0] image_r,
  // Read answer
  output logic [31:0] rd_data_r,
  output logic rd_valid_r,
  // Condition-field copy answer
  output logic [3:0] crf_data_r,
  output logic crf_valid_r,
  // Completion acknowledge
  output logic done_r
);

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] field_bits(input logic [2:0] idx);
    logic [31:0] m;
    // Shift amount built as idx times four without losing the carry bits
    m = 32'h0000_000F << {idx, 2'b00};
    return m;
  endfunction : field_bits

  function automatic logic [31:0] nibble_at(input logic [2:0] idx, input logic [3:0] nib);
    logic [31:0] v;
    v = {28'h000_0000, nib} << {idx, 2'b00};
    return v;
  endfunction : nibble_at

  function automatic logic [31:0] one_bit(input logic [4:0] idx);
    logic [31:0] v;
    v = 32'h0000_0001 << idx;
    return v;
  endfunction : one_bit

  // ==========================================================================
  // Status next value
  logic [31:0] status_cur;
  logic [31:0] after_move;
  logic [31:0] after_pipe;
  logic [31:0] status_nxt;
  logic [31:0] image_nxt;
  logic [31:0] pipe_set;
  logic [31:0] move_mask;
  logic [31:0] fmask;
  logic [3:0] crf_nxt;
  logic frac_inexact_new;
  logic exc_sum_implicit;
  logic implicit_ok;
  logic op_read;
  logic op_copy;
  logic vx_sum;
  logic fex_sum;

  assign status_cur = image_r & fp_status_pkg::STATUS_MASK;

  // Stage 1: explicit moves
  always_comb begin
    after_move = status_cur;
    move_mask = 32'h0000_0000;
    fmask = 32'h0000_0000;
    crf_nxt = 4'h0;
    op_read = 1'b0;
    op_copy = 1'b0;
    implicit_ok = 1'b0;
    if (move_req.valid) begin
      unique case (move_req.op)
        fp_status_pkg::MOVE_READ: begin
          op_read = 1'b1;
        end
        fp_status_pkg::MOVE_COPY_CRF: begin
          op_copy = 1'b1;
          crf_nxt = 4'((status_cur >> {move_req.field, 2'b00}) & 32'h0000_000F);
          // Only sticky bits of the field are cleared; summaries recomputed
          move_mask = field_bits(move_req.field) & fp_status_pkg::STICKY_MASK;
          after_move = status_cur & ~move_mask;
        end
        fp_status_pkg::MOVE_IMM_FIELD: begin
          // Control fields are owned elsewhere; writes there are dropped
          move_mask = field_bits(move_req.field) & fp_status_pkg::WRITABLE_MASK;
          after_move = (status_cur & ~move_mask) |
                       (nibble_at(move_req.field, move_req.imm) & move_mask);
        end
        fp_status_pkg::MOVE_FIELD: begin
          for (int k = 0; k < fp_status_pkg::STATUS_FIELDS; k++) begin
            if (move_req.field_mask[k]) begin
              fmask = fmask | field_bits(3'(k));
            end
          end
          move_mask = fmask & fp_status_pkg::WRITABLE_MASK;
          after_move = (status_cur & ~move_mask) | (move_req.data & move_mask);
        end
        fp_status_pkg::MOVE_BIT_CLR: begin
          move_mask = one_bit(move_req.bit_idx) & fp_status_pkg::WRITABLE_MASK;
          after_move = status_cur & ~move_mask;
          implicit_ok = 1'b1;
        end
        fp_status_pkg::MOVE_BIT_SET: begin
          move_mask = one_bit(move_req.bit_idx) & fp_status_pkg::WRITABLE_MASK;
          after_move = status_cur | move_mask;
          implicit_ok = 1'b1;
        end
        default: begin
          after_move = status_cur;
        end
      endcase
    end
  end

  // Stage 2: completion report, applied on top so a set beats a same-cycle clear
  always_comb begin
    pipe_set = 32'h0000_0000;
    frac_inexact_new = 1'b0;
    after_pipe = after_move;
    if (pipe_report.valid) begin
      pipe_set[fp_status_pkg::BIT_OVERFLOW_EXC] = pipe_report.overflow;
      pipe_set[fp_status_pkg::BIT_UNDERFLOW_EXC] = pipe_report.underflow;
      pipe_set[fp_status_pkg::BIT_ZERO_DIVIDE_EXC] = pipe_report.zero_divide;
      pipe_set[fp_status_pkg::BIT_INVALID_COMPARE:fp_status_pkg::BIT_INVALID_SIGNALLING_NAN] =
        pipe_report.invalid_cause;
      pipe_set[fp_status_pkg::BIT_INVALID_SQUARE_ROOT] = pipe_report.invalid_square_root;
      pipe_set[fp_status_pkg::BIT_INVALID_INT_CONVERT] = pipe_report.invalid_int_convert;
      // Pipeline has no path to the software-request bit
      pipe_set = pipe_set & ~one_bit(5'(fp_status_pkg::BIT_INVALID_SOFTWARE_REQUEST));
      frac_inexact_new = pipe_report.fraction_inexact |
               (pipe_report.overflow & ~ctrl_bits[fp_status_pkg::BIT_EN_OVERFLOW -
                                                   fp_status_pkg::BIT_CTRL_LO]);
      if (pipe_report.inexact_affect) begin
        after_pipe[fp_status_pkg::BIT_FRACTION_INEXACT] = frac_inexact_new;
        pipe_set[fp_status_pkg::BIT_STICKY_INEXACT] = frac_inexact_new;
      end
      if (pipe_report.rounded_affect) begin
        after_pipe[fp_status_pkg::BIT_FRACTION_ROUNDED] = pipe_report.fraction_rounded;
      end
      if (pipe_report.is_compare) begin
        // Exactly one condition bit; class bit left alone
        after_pipe = after_pipe & ~fp_status_pkg::COND_CODE_MASK;
        after_pipe = after_pipe |
          one_bit(5'(fp_status_pkg::BIT_FP_CONDITION_CODE) + 5'(pipe_report.cmp_result));
      end else if (pipe_report.flags_affect) begin
        after_pipe = after_pipe & ~fp_status_pkg::RESULT_FLAGS_MASK;
        after_pipe = after_pipe |
          ({27'h000_0000, pipe_report.result_flags} << fp_status_pkg::BIT_RESULT_CLASS);
      end
      after_pipe = after_pipe | pipe_set;
    end
  end

  // Stage 3: implicit summary and derived bits
  always_comb begin
    // Field moves may raise exceptions without touching the summary
    exc_sum_implicit = (pipe_report.valid | implicit_ok) &
                  (|(fp_status_pkg::EXC_MASK & ~status_cur & after_pipe));
    status_nxt = after_pipe;
    if (exc_sum_implicit) begin
      status_nxt[fp_status_pkg::BIT_EXC_SUMMARY] = 1'b1;
    end
    // Written values of summary bits 1 and 2 never survive: recompute here
    status_nxt = status_nxt & ~fp_status_pkg::DERIVED_MASK &
                 ~fp_status_pkg::RESERVED_MASK;
    status_nxt[fp_status_pkg::BIT_INVALID_OP_SUMMARY] = vx_sum;
    status_nxt[fp_status_pkg::BIT_ENABLED_EXC_SUMMARY] = fex_sum;
    image_nxt = {ctrl_bits, status_nxt[23:0]};
  end

  // ==========================================================================
  // Summary calculator
  // Fed from pre-summary value so no loop through the summary bits
  fp_summary_calc u_summary (
    .status (after_pipe),
    .ctrl_bits (ctrl_bits),
    .invalid_op_summary (vx_sum),
    .enabled_exc_summary (fex_sum)
  );

  // ==========================================================================
  // Register image
  // Enabled summary lags an enable change by one cycle, since the image is registered
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      image_r <= fp_status_pkg::REG_RESET;
    end else begin
      image_r <= image_nxt;
    end
  end

  // ==========================================================================
  // Read answer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= 32'h0000_0000;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= op_read;
      if (op_read) begin
        rd_data_r <= image_r;
      end
    end
  end

  // ==========================================================================
  // Condition-field copy answer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      crf_data_r <= 4'h0;
      crf_valid_r <= 1'b0;
    end else begin
      crf_valid_r <= op_copy;
      if (op_copy) begin
        crf_data_r <= crf_nxt;
      end
    end
  end

  // ==========================================================================
  // Completion acknowledge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      done_r <= 1'b0;
    end else begin
      done_r <= pipe_report.valid;
    end
  end

endmodule : fp_status_control_register

// *** sim/fp_status_checker.sv ***
// Port checker for the floating-point status register.
// Assumes one core clock domain; attached by the bind at the foot.
module fp_status_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Requests
  input wire fp_status_pkg::pipe_report_t pipe_report,
  input wire fp_status_pkg::move_req_t move_req,
  input wire logic [7:0] ctrl_bits,
  // Answers
  input wire logic [31:0] image_r,
  input wire logic [31:0] rd_data_r,
  input wire logic rd_valid_r,
  input wire logic [3:0] crf_data_r,
  input wire logic crf_valid_r,
  input wire logic done_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mv;
  logic rp;
  logic [1:0] cmp_k;
  assign mv = move_req.valid;
  assign rp = pipe_report.valid;
  assign cmp_k = pipe_report.cmp_result;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Assertions
  done_pulse_a: assert property (rp |=> done_r ##1 ($past(rp) || !done_r))
    else $error("done pulse wrong");
  image_ctrl_a: assert property ($past(rst_b) |-> image_r[31:24] == $past(ctrl_bits))
    else $error("control byte not mirrored");
  status_hold_a: assert property (!rp && !mv |=> $stable(image_r[23:2]) && $stable(image_r[0]))
    else $error("status moved without a request");
  sticky_keep_a: assert property (!mv |=> ((image_r & $past(image_r) & fp_status_pkg::STICKY_MASK)
    == ($past(image_r) & fp_status_pkg::STICKY_MASK)))
    else $error("sticky bit dropped");
  fx_rise_a: assert property (rp && pipe_report.overflow && !image_r[3] && !mv
    |=> image_r[0] && image_r[3])
    else $error("summary not set on new exception");
  enabled_sum_a: assert property (image_r[1] == |(image_r[6:2] & image_r[28:24]))
    else $error("enabled summary wrong");
  invalid_sum_a: assert property (image_r[2] == |(image_r & fp_status_pkg::INVALID_MASK))
    else $error("invalid summary wrong");
  inexact_or_a: assert property (rp && pipe_report.inexact_affect && pipe_report.fraction_inexact
    && !mv |=> image_r[6] && image_r[14])
    else $error("inexact bits not set");
  compare_one_a: assert property (rp && pipe_report.is_compare && !mv
    |=> image_r[19:16] == 4'h1 << $past(cmp_k))
    else $error("condition code not one-hot");
  soft_req_a: assert property (!mv |=> $stable(image_r[21]))
    else $error("software request bit changed");
  cover property (rp && pipe_report.is_compare);
  cover property (mv && move_req.op == fp_status_pkg::MOVE_COPY_CRF);
  cover property (mv && move_req.op == fp_status_pkg::MOVE_FIELD);
endmodule : fp_status_checker

bind fp_status_control_register fp_status_checker chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .pipe_report(pipe_report), .move_req(move_req), .ctrl_bits(ctrl_bits), .image_r(image_r),
  .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .crf_data_r(crf_data_r),
  .crf_valid_r(crf_valid_r), .done_r(done_r));

// *** sim/fp_far_side_model.sv ***
// Far side: pipeline completions and move instructions.
// Assumes the bench calls its tasks; requests launch 1 ns after a rising edge.
module fp_far_side_model (
  // Clock
  input wire logic clk_sys,
  // Requests
  output fp_status_pkg::pipe_report_t pipe_report,
  output fp_status_pkg::move_req_t move_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pipe_report = '0;
    move_req = '0;
  end
  // One-cycle pulses; idle is all zero so no stale field looks valid
  task automatic report(input fp_status_pkg::pipe_report_t r);
    r.valid = 1'b1;
    @(posedge clk_sys);
    #1 pipe_report = r;
    @(posedge clk_sys);
    #1 pipe_report = '0;
  endtask : report
  task automatic move(input fp_status_pkg::move_op_t op, input logic [4:0] bi,
    input logic [2:0] fld, input logic [3:0] imm, input logic [7:0] msk, input logic [31:0] d);
    @(posedge clk_sys);
    #1 move_req = {1'b1, op, fld, bi, imm, msk, d};
    @(posedge clk_sys);
    #1 move_req = '0;
  endtask : move
endmodule : fp_far_side_model

// *** sim/fp_status_control_register_bench.sv ***
// Self-checking bench for the floating-point status register.
// Assumes the far-side model drives requests; the bench owns the control byte.
module fp_status_control_register_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys;
  logic rst_b;
  logic [7:0] ctrl_bits;
  logic [31:0] image, rd_data, exp;
  logic [3:0] crf_data;
  logic rd_valid, crf_valid, done;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  fp_status_pkg::pipe_report_t pipe_report, rp;
  fp_status_pkg::move_req_t move_req;

  fp_far_side_model far (.clk_sys(clk_sys), .pipe_report(pipe_report), .move_req(move_req));
  fp_status_control_register dut (.clk_sys(clk_sys), .rst_b(rst_b), .pipe_report(pipe_report),
    .move_req(move_req), .ctrl_bits(ctrl_bits), .image_r(image), .rd_data_r(rd_data),
    .rd_valid_r(rd_valid), .crf_data_r(crf_data), .crf_valid_r(crf_valid), .done_r(done));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check
  // Summaries worked out from the expected image, never from the design
  function automatic logic [31:0] fix(input logic [31:0] v);
    v[2] = |(v & fp_status_pkg::INVALID_MASK);
    v[1] = |(v[6:2] & v[28:24]);
    return v;
  endfunction : fix
  task automatic rep(input fp_status_pkg::pipe_report_t r, input logic [31:0] set,
    input logic [31:0] clr);
    far.report(r);
    exp = fix((exp & ~clr) | set);
    check(done, 32'h1);
    check(image, exp);
  endtask : rep
  task automatic mvc(input fp_status_pkg::move_op_t op, input logic [4:0] bi,
    input logic [2:0] fld, input logic [3:0] imm, input logic [7:0] msk, input logic [31:0] d,
    input logic [31:0] nxt);
    far.move(op, bi, fld, imm, msk, d);
    exp = fix(nxt);
    check(image, exp);
  endtask : mvc
  task automatic setctl(input logic [7:0] v);
    ctrl_bits = v;
    repeat (2) @(posedge clk_sys);
    #1 exp = fix({v, exp[23:0]});
    check(image, exp);
  endtask : setctl
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // Hang guard: whole run needs about 63 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Tests
  initial begin
    rst_b = 1'b0;
    ctrl_bits = 8'h00;
    exp = 32'h0000_0000;
    repeat (3) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check(image, 32'h0000_0000);
    rp = '0;
    rp.overflow = 1'b1;
    rep(rp, 32'h0000_0009, 32'h0);
    rp = '0;
    rp.underflow = 1'b1;
    rp.zero_divide = 1'b1;
    rep(rp, 32'h0000_0030, 32'h0);
    rp = '0;
    rep(rp, 32'h0, 32'h0);
    for (int k = 0; k < 6; k++) begin
      rp = '0;
      rp.invalid_cause = 6'h01 << k;
      rep(rp, 32'h0000_0080 << k, 32'h0);
    end
    rp = '0;
    rp.invalid_square_root = 1'b1;
    rp.invalid_int_convert = 1'b1;
    rep(rp, 32'h00C0_0000, 32'h0);
    $display("test exceptions finished");
    setctl(8'h1F);
    setctl(8'h00);
    $display("test enables finished");
    rp = '0;
    rp.inexact_affect = 1'b1;
    rp.fraction_inexact = 1'b1;
    rp.rounded_affect = 1'b1;
    rp.fraction_rounded = 1'b1;
    rep(rp, 32'h0000_6040, 32'h0);
    rp.fraction_inexact = 1'b0;
    rp.fraction_rounded = 1'b0;
    rep(rp, 32'h0, 32'h0000_6000);
    rp = '0;
    rp.inexact_affect = 1'b1;
    rp.overflow = 1'b1;
    rep(rp, 32'h0000_4000, 32'h0);
    for (int k = 0; k < 4; k++) begin
      rp = '0;
      rp.is_compare = 1'b1;
      rp.cmp_result = fp_status_pkg::cmp_result_t'(k);
      rep(rp, 32'h0001_0000 << k, 32'h000F_0000);
    end
    // Result flags: low flag bit lands on the class bit, the rest on the condition code
    rp = '0;
    rp.flags_affect = 1'b1;
    rp.result_flags = 5'h03;
    rep(rp, 32'h0001_8000, 32'h000F_8000);
    $display("test results finished");
    far.move(fp_status_pkg::MOVE_READ, 5'h00, 3'h0, 4'h0, 8'h00, 32'h0);
    check(rd_valid, 32'h1);
    check(rd_data, exp);
    far.move(fp_status_pkg::MOVE_COPY_CRF, 5'h00, 3'h0, 4'h0, 8'h00, 32'h0);
    check(crf_valid, 32'h1);
    check(crf_data, exp[3:0]);
    exp = fix(exp & ~32'h0000_0009);
    check(image, exp);
    mvc(fp_status_pkg::MOVE_BIT_SET, 5'h15, 3'h0, 4'h0, 8'h00, 32'h0, exp | 32'h0020_0001);
    mvc(fp_status_pkg::MOVE_BIT_CLR, 5'h00, 3'h0, 4'h0, 8'h00, 32'h0, exp & ~32'h1);
    mvc(fp_status_pkg::MOVE_BIT_SET, 5'h01, 3'h0, 4'h0, 8'h00, 32'h0, exp);
    mvc(fp_status_pkg::MOVE_FIELD, 5'h00, 3'h0, 4'h0, 8'h01, 32'hF, exp | 32'h9);
    mvc(fp_status_pkg::MOVE_BIT_CLR, 5'h00, 3'h0, 4'h0, 8'h00, 32'h0, exp & ~32'h1);
    mvc(fp_status_pkg::MOVE_IMM_FIELD, 5'h00, 3'h1, 4'h0, 8'h00, 32'h0, exp & ~32'hF0);
    mvc(fp_status_pkg::MOVE_FIELD, 5'h00, 3'h0, 4'h0, 8'h02, 32'hF0, exp | 32'hF0);
    $display("test moves finished");
    give_verdict();
  end
endmodule : fp_status_control_register_bench
